// *** shared/io_cell_pkg.sv ***
// Constants for the programmable I/O cell bank and its APB register map.
// Summary of operation
// - Every cell has an input capture stage, an output stage and a drive-enable stage.
// - The input stage can optionally register the pad value before the core sees it.
// - The output stage optionally registers core data; otherwise core data passes through.
// - While the bank freeze is on, selected unregistered inputs keep their value.
// - One freeze control serves every cell of the bank.
// - The freeze leaves registered inputs alone; their clock enable holds them.
// - Asserting freeze latches the present input value until freeze is released.
// - Before configuration every pad is high impedance with its weak pull-up on.
// - User settings apply only after reset release and configuration completion.
// - Unused pads have their input path blocked and pull-up turned off.
// - Each pad selects weak pull-up or no termination on its own.
package io_cell_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CONFIG_DONE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_USED_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IN_REG_SEL  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OUT_REG_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PULL_SEL    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_HOLD_SEL    = 8'h14;
  localparam logic [ADDR_W-1:0] REG_PAD_STATE   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CORE_STATE  = 8'h1c;

  // Field position of the configuration-complete flag.
  localparam int unsigned CONFIG_DONE_BIT = 0;

  // Reset value of the per-pin selection registers.
  localparam logic RESET_SEL = 1'b0;

endpackage

// *** design/io_cell_bank.sv ***
// A bank of programmable I/O cells with an APB register file.
`timescale 1ns/1ps
module io_cell_bank
  import io_cell_pkg::*;
#(
  parameter int unsigned PINS = 8
) (
  // Clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core side
  input  wire logic              clockEnable,
  input  wire logic              captureTick,
  input  wire logic              driveTick,
  input  wire logic              bankFreeze,
  input  wire logic [PINS-1:0]   coreOut,
  input  wire logic [PINS-1:0]   coreDriveEn,
  output logic      [PINS-1:0]   coreIn,
  // Pad side
  input  wire logic [PINS-1:0]   padIn,
  output logic      [PINS-1:0]   padOut,
  output logic      [PINS-1:0]   padOe,
  output logic      [PINS-1:0]   padPullUp
);

  // Software settings.
  logic            configDone;
  logic [PINS-1:0] usedMask;
  logic [PINS-1:0] inRegSel;
  logic [PINS-1:0] outRegSel;
  logic [PINS-1:0] pullSel;
  logic [PINS-1:0] holdSel;
  logic            next_configDone;
  logic [PINS-1:0] next_usedMask;
  logic [PINS-1:0] next_inRegSel;
  logic [PINS-1:0] next_outRegSel;
  logic [PINS-1:0] next_pullSel;
  logic [PINS-1:0] next_holdSel;
  logic [DATA_W-1:0] next_prdata;

  // Cell state.
  logic [PINS-1:0] padMeta;
  logic [PINS-1:0] padSync2;
  logic [PINS-1:0] padSync3;
  logic [PINS-1:0] padStable;
  logic [PINS-1:0] inCapture;
  logic [PINS-1:0] heldValue;
  logic [PINS-1:0] outCapture;
  logic [PINS-1:0] oeCapture;
  logic [PINS-1:0] next_padStable;
  logic [PINS-1:0] next_inCapture;
  logic [PINS-1:0] next_heldValue;
  logic [PINS-1:0] next_outCapture;
  logic [PINS-1:0] next_oeCapture;
  logic [PINS-1:0] next_coreIn;
  logic [PINS-1:0] next_padOut;
  logic [PINS-1:0] next_padOe;
  logic [PINS-1:0] next_padPullUp;

  logic            captureEn;
  logic            driveEn;
  logic [PINS-1:0] unregValue;
  logic [PINS-1:0] dataSel;
  logic [PINS-1:0] oeSel;
  logic            writeAccess;
  logic            setupPhase;
  logic            mapped;

  // Every access completes in its first access cycle.
  assign pready      = 1'b1;
  assign setupPhase  = psel && !penable;
  assign writeAccess = psel && penable && pwrite;

  always_comb begin
    unique case (paddr)
      REG_CONFIG_DONE, REG_USED_MASK, REG_IN_REG_SEL, REG_OUT_REG_SEL,
      REG_PULL_SEL, REG_HOLD_SEL, REG_PAD_STATE, REG_CORE_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  always_comb begin
    next_configDone = configDone;
    next_usedMask   = usedMask;
    next_inRegSel   = inRegSel;
    next_outRegSel  = outRegSel;
    next_pullSel    = pullSel;
    next_holdSel    = holdSel;
    next_prdata     = prdata;
    if (writeAccess) begin
      unique case (paddr)
        REG_CONFIG_DONE: next_configDone = pwdata[CONFIG_DONE_BIT];
        REG_USED_MASK:   next_usedMask   = pwdata[PINS-1:0];
        REG_IN_REG_SEL:  next_inRegSel   = pwdata[PINS-1:0];
        REG_OUT_REG_SEL: next_outRegSel  = pwdata[PINS-1:0];
        REG_PULL_SEL:    next_pullSel    = pwdata[PINS-1:0];
        REG_HOLD_SEL:    next_holdSel    = pwdata[PINS-1:0];
        default: ;
      endcase
    end
    // Read data is loaded in the setup cycle so that it comes from a flip-flop.
    if (setupPhase) begin
      unique case (paddr)
        REG_CONFIG_DONE: next_prdata = DATA_W'(configDone);
        REG_USED_MASK:   next_prdata = DATA_W'(usedMask);
        REG_IN_REG_SEL:  next_prdata = DATA_W'(inRegSel);
        REG_OUT_REG_SEL: next_prdata = DATA_W'(outRegSel);
        REG_PULL_SEL:    next_prdata = DATA_W'(pullSel);
        REG_HOLD_SEL:    next_prdata = DATA_W'(holdSel);
        REG_PAD_STATE:   next_prdata = DATA_W'(padStable);
        REG_CORE_STATE:  next_prdata = DATA_W'(coreIn);
        default:         next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      configDone <= 1'b0;
      usedMask   <= {PINS{RESET_SEL}};
      inRegSel   <= {PINS{RESET_SEL}};
      outRegSel  <= {PINS{RESET_SEL}};
      pullSel    <= {PINS{RESET_SEL}};
      holdSel    <= {PINS{RESET_SEL}};
      prdata     <= '0;
    end else begin
      configDone <= next_configDone;
      usedMask   <= next_usedMask;
      inRegSel   <= next_inRegSel;
      outRegSel  <= next_outRegSel;
      pullSel    <= next_pullSel;
      holdSel    <= next_holdSel;
      prdata     <= next_prdata;
    end
  end

  // Pad synchroniser: a change counts once the second and third stages agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      padMeta  <= '0;
      padSync2 <= '0;
      padSync3 <= '0;
    end else begin
      padMeta  <= padIn;
      padSync2 <= padMeta;
      padSync3 <= padSync2;
    end
  end

  // Both register ticks share the one clock enable.
  assign captureEn = clockEnable && captureTick;
  assign driveEn   = clockEnable && driveTick;

  // The single bank-wide freeze gates every selected unregistered input.
  assign unregValue = (bankFreeze ? holdSel : '0) & heldValue
                    | ~(bankFreeze ? holdSel : '0) & padStable;
  assign dataSel    = (outRegSel & outCapture) | (~outRegSel & coreOut);
  assign oeSel      = (outRegSel & oeCapture) | (~outRegSel & coreDriveEn);

  always_comb begin
    next_padStable  = (padSync2 & padSync3) | (padStable & (padSync2 ^ padSync3));
    next_inCapture  = captureEn ? padStable : inCapture;
    // The latch follows the pad until freeze rises, then keeps that value.
    next_heldValue  = bankFreeze ? heldValue : padStable;
    next_outCapture = driveEn ? coreOut : outCapture;
    next_oeCapture  = driveEn ? coreDriveEn : oeCapture;
    if (configDone) begin
      next_coreIn    = usedMask & ((inRegSel & inCapture) | (~inRegSel & unregValue));
      next_padOe     = usedMask & oeSel;
      next_padOut    = next_padOe & dataSel;
      next_padPullUp = usedMask & pullSel;
    end else begin
      next_coreIn    = '0;
      next_padOe     = '0;
      next_padOut    = '0;
      next_padPullUp = '1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      padStable  <= '0;
      inCapture  <= '0;
      heldValue  <= '0;
      outCapture <= '0;
      oeCapture  <= '0;
      coreIn     <= '0;
      padOut     <= '0;
      padOe      <= '0;
      padPullUp  <= '1;
    end else begin
      padStable  <= next_padStable;
      inCapture  <= next_inCapture;
      heldValue  <= next_heldValue;
      outCapture <= next_outCapture;
      oeCapture  <= next_oeCapture;
      coreIn     <= next_coreIn;
      padOut     <= next_padOut;
      padOe      <= next_padOe;
      padPullUp  <= next_padPullUp;
    end
  end

  // Checks on the cell behaviour.
  logic [PINS-1:0] frozenMask;
  assign frozenMask = usedMask & ~inRegSel & holdSel;

  preconfig_hiz_a: assert property (@(posedge clk) disable iff (rst)
    !$past(configDone) |-> (padOe == '0) && (padPullUp == '1))
    else $error("pad not high impedance with pull-up before configuration");

  unused_block_a: assert property (@(posedge clk) disable iff (rst)
    $past(configDone) |-> ((padOe | padPullUp | coreIn) & ~$past(usedMask)) == '0)
    else $error("unused pad not blocked");

  drive_gate_a: assert property (@(posedge clk) disable iff (rst)
    (padOut & ~padOe) == '0)
    else $error("pad data present while not driven");

  // Freeze must still be sampled high in the cycle that launches the compared value,
  // otherwise its release lawfully lets the pad through on that very edge.
  freeze_hold_a: assert property (@(posedge clk) disable iff (rst)
    bankFreeze ##1 (bankFreeze && configDone && $past(configDone) && $stable(frozenMask))
      ##1 $stable(frozenMask) |-> $stable(coreIn & frozenMask))
    else $error("frozen input changed");

  hold_capture_a: assert property (@(posedge clk) disable iff (rst)
    !bankFreeze |=> heldValue == $past(padStable))
    else $error("hold latch did not follow the pad while open");

  // Used unregistered pins outside the frozen set keep tracking the synchronised pad.
  unreg_follow_a: assert property (@(posedge clk) disable iff (rst)
    $past(configDone) |-> ((coreIn ^ $past(padStable))
      & $past(usedMask & ~inRegSel & ~({PINS{bankFreeze}} & holdSel))) == '0)
    else $error("unfrozen unregistered input did not follow the pad");

  // A pad bit only moves once the second and third stages agree on it.
  pad_agree_a: assert property (@(posedge clk) disable iff (rst)
    (((padStable ^ $past(padStable)) & $past(padSync2 ^ padSync3)) == '0)
      && (((padStable ^ $past(padSync3)) & ~$past(padSync2 ^ padSync3)) == '0))
    else $error("pad level accepted before the synchroniser settled");

  capture_gate_a: assert property (@(posedge clk) disable iff (rst)
    !$past(captureEn) |-> $stable(inCapture))
    else $error("capture register moved without its tick");

  drive_gate_reg_a: assert property (@(posedge clk) disable iff (rst)
    !$past(driveEn) |-> $stable(outCapture) && $stable(oeCapture))
    else $error("drive register moved without its tick");

  pass_through_a: assert property (@(posedge clk) disable iff (rst)
    $past(configDone) |->
      ((padOut ^ $past(coreOut)) & $past(usedMask & ~outRegSel) & padOe) == '0)
    else $error("unregistered output did not pass straight through");

  reg_input_a: assert property (@(posedge clk) disable iff (rst)
    $past(configDone) |-> ((coreIn ^ $past(inCapture)) & $past(usedMask & inRegSel)) == '0)
    else $error("registered input not taken from capture register");

  pull_select_a: assert property (@(posedge clk) disable iff (rst)
    $past(configDone) |-> padPullUp == $past(usedMask & pullSel))
    else $error("pull-up does not follow its selection");

  oe_follow_a: assert property (@(posedge clk) disable iff (rst)
    $past(configDone) |-> padOe == $past(usedMask & oeSel))
    else $error("pad drive enable does not follow its selection");

  // Settings take hold on the first edge after configuration completes.
  config_apply_a: assert property (@(posedge clk) disable iff (rst)
    $rose(configDone) |=> (padOe == $past(usedMask & oeSel))
      && (padPullUp == $past(usedMask & pullSel)))
    else $error("settings not applied after configuration");

  config_block_a: assert property (@(posedge clk) disable iff (rst)
    !$past(configDone) |-> coreIn == '0)
    else $error("core saw pad data before configuration");

  // A write lands on the access edge, so the next cycle already shows it.
  mask_write_a: assert property (@(posedge clk) disable iff (rst)
    psel && penable && pwrite && (paddr == REG_USED_MASK)
      |=> usedMask == $past(pwdata[PINS-1:0]))
    else $error("used-pin mask write did not land");

  // The main scenarios: configuration, freeze, drive, capture and a refused access.
  config_cover: cover property (@(posedge clk) disable iff (rst)
    !configDone ##1 configDone);
  capture_cover: cover property (@(posedge clk) disable iff (rst)
    configDone && captureEn && (inRegSel != '0));
  freeze_cover: cover property (@(posedge clk) disable iff (rst)
    configDone && (frozenMask != '0) && bankFreeze [*4]);
  drive_cover: cover property (@(posedge clk) disable iff (rst)
    configDone && driveEn ##1 (padOe != '0));
  slverr_cover: cover property (@(posedge clk) disable iff (rst) pslverr);

endmodule

// *** sim/pad_board_model.sv ***
// Board-side model of the pads: device drive, external drivers, pull-ups, floating lines.
`timescale 1ns/1ps
module pad_board_model #(
  parameter int unsigned PINS = 8
) (
  // Clock for the floating-line pattern
  input  wire logic            clk,
  // Device pad side
  input  wire logic [PINS-1:0] padOut,
  input  wire logic [PINS-1:0] padOe,
  input  wire logic [PINS-1:0] padPullUp,
  output logic      [PINS-1:0] padIn,
  // External drivers on the board
  input  wire logic [PINS-1:0] extEn,
  input  wire logic [PINS-1:0] extVal
);
  logic flip = 1'b0;

  // A released line with no pull-up toggles so a stale value is never mistaken for data.
  always @(posedge clk) flip <= ~flip;

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extEn[i]) padIn[i] = extVal[i];
      else if (padPullUp[i]) padIn[i] = 1'b1;
      else padIn[i] = flip;
    end
  end
endmodule

// *** sim/io_cell_bank_bench.sv ***
// Self-checking bench for the I/O cell bank: APB setup, drive, capture and freeze.
`timescale 1ns/1ps
module io_cell_bank_bench
  import io_cell_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, clockEnable = 0, captureTick = 0, driveTick = 0, bankFreeze = 0;
  logic [7:0] coreOut = '0, coreDriveEn = '0, coreIn, padIn, padOut, padOe, padPullUp;
  logic [7:0] extEn = '0, extVal = '0;
  int nFail = 0, nCompared = 0, cycles = 0;

  io_cell_bank #(.PINS(8)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clockEnable(clockEnable), .captureTick(captureTick),
    .driveTick(driveTick), .bankFreeze(bankFreeze), .coreOut(coreOut),
    .coreDriveEn(coreDriveEn), .coreIn(coreIn), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .padPullUp(padPullUp));
  pad_board_model #(.PINS(8)) board (.clk(clk), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padIn(padIn), .extEn(extEn), .extVal(extVal));

  always #5 clk = ~clk;

  task automatic completeRun();
    $display("compared %0d mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // The run is under a hundred cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      completeRun();
    end
  end

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse(input logic ce, input logic cap, input logic drv);
    @(posedge clk);
    clockEnable <= ce;
    captureTick <= cap;
    driveTick <= drv;
    @(posedge clk);
    clockEnable <= 1'b0;
    captureTick <= 1'b0;
    driveTick <= 1'b0;
  endtask

  initial begin
    waitc(4);
    rst <= 1'b0;
    coreOut <= 8'hff;
    coreDriveEn <= 8'hff;
    waitc(3);
    check(32'(padOe), 32'h0);
    check(32'(padPullUp), 32'hff);
    check(32'(coreIn), 32'h0);
    apb(1'b0, REG_USED_MASK, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    $display("test reset done");
    apb(1'b1, REG_USED_MASK, 32'h0f);
    apb(1'b1, REG_PULL_SEL, 32'h05);
    apb(1'b1, REG_CONFIG_DONE, 32'h01);
    waitc(2);
    check(32'(padPullUp), 32'h05);
    check(32'(padOe), 32'h0f);
    check(32'(padOut), 32'h0f);
    apb(1'b0, REG_PULL_SEL, 32'h0);
    check(rd, 32'h05);
    coreOut <= 8'h0a;
    waitc(2);
    check(32'(padOut), 32'h0a);
    $display("test drive done");
    coreDriveEn <= 8'h00;
    extEn <= 8'hff;
    extVal <= 8'ha5;
    waitc(7);
    check(32'(coreIn), 32'h05);
    apb(1'b1, REG_HOLD_SEL, 32'h0f);
    apb(1'b1, REG_IN_REG_SEL, 32'h01);
    pulse(1'b1, 1'b1, 1'b0);
    bankFreeze <= 1'b1;
    waitc(2);
    extVal <= 8'h5a;
    waitc(7);
    pulse(1'b1, 1'b1, 1'b0);
    waitc(2);
    check(32'(coreIn), 32'h04);
    bankFreeze <= 1'b0;
    waitc(3);
    check(32'(coreIn), 32'h0a);
    extVal <= 8'ha5;
    waitc(7);
    pulse(1'b0, 1'b1, 1'b0);
    waitc(2);
    check(32'(coreIn & 8'h01), 32'h0);
    apb(1'b0, REG_CORE_STATE, 32'h0);
    check(rd, 32'h04);
    apb(1'b0, REG_PAD_STATE, 32'h0);
    check(rd, 32'ha5);
    $display("test capture done");
    apb(1'b1, REG_OUT_REG_SEL, 32'h0f);
    extEn <= 8'h00;
    coreDriveEn <= 8'h0f;
    coreOut <= 8'h03;
    pulse(1'b0, 1'b0, 1'b1);
    waitc(2);
    check(32'(padOe), 32'h0);
    pulse(1'b1, 1'b0, 1'b1);
    waitc(2);
    check(32'(padOe), 32'h0f);
    check(32'(padOut), 32'h03);
    apb(1'b1, REG_CONFIG_DONE, 32'h0);
    waitc(2);
    check(32'(padOe), 32'h0);
    check(32'(padPullUp), 32'hff);
    $display("test registered drive done");
    completeRun();
  end
endmodule
